// ---- sjx_pkg.sv ----
/*
 * Package for the skip-and-jump execute block: opcode patterns, field
 * positions, widths and the packed carriers between fetch, execute and
 * the register file / program counter.
 * Assumes a core with 14-bit instruction words and an 8-bit data path.
 */
// Operation
// - Decrement-skip writes f-1 to W or f
// - Zero result flushes prefetch, two cycles
// - Decode decrement-skip opcode; flags untouched
// - Jump loads literal and latch bits 4:3
// - Jump decoded, two cycles, flags untouched
// - Increment-skip writes f+1 to W or f
// - Zero result flushes prefetch; flags untouched
package sjx_pkg;

    // ==========================================================
    // Widths
    localparam int SJX_IW       = 14;
    localparam int SJX_DW       = 8;
    localparam int SJX_AW       = 7;
    localparam int SJX_PCW      = 13;
    localparam int SJX_LITW     = 11;

    // ==========================================================
    // Opcode patterns and field positions
    localparam logic [5:0] SJX_OP_DEC_SKIP = 6'h0b;
    localparam logic [5:0] SJX_OP_INC_SKIP = 6'h0f;
    localparam logic [2:0] SJX_OP_JUMP     = 3'h5;
    localparam int SJX_DEST_BIT   = 7;
    localparam int SJX_SKIP_OP_LO = 8;
    localparam int SJX_JUMP_OP_LO = 11;
    localparam int SJX_LATCH_LO   = 3;
    localparam int SJX_LATCH_HI   = 4;

    // ==========================================================
    // Reset values
    localparam logic [SJX_IW-1:0] SJX_NOP_WORD = 14'h0000;
    localparam logic              SJX_FLUSH_RESET = 1'b0;

    typedef enum logic [1:0] {
        SJX_EXECUTE = 2'b01,
        SJX_FLUSH   = 2'b10
    } sjx_state_type;

    typedef struct packed {
        logic              valid;
        logic [SJX_IW-1:0] word;
    } sjx_fetch_type;

    typedef struct packed {
        logic              we_file;
        logic              we_w;
        logic [SJX_AW-1:0] addr;
        logic [SJX_DW-1:0] data;
    } sjx_write_type;

    typedef struct packed {
        logic               load;
        logic [SJX_PCW-1:0] target;
    } sjx_jump_type;

endpackage : sjx_pkg

// ---- sjx_exec.sv ----
/*
 * Execute logic for decrement-skip, increment-skip and the unconditional
 * jump. Takes one fetched word per cycle, reads the addressed register
 * combinationally and returns registered write-back and jump requests.
 * Assumes the register file answers i_file_data in the same cycle as
 * o_file_addr, and that the fetch unit refetches after a jump load.
 */
`timescale 1ns/1ps
`default_nettype none
module sjx_exec (
    input  wire logic                       i_clock,
    input  wire logic                       i_rst_n,
    input  wire sjx_pkg::sjx_fetch_type     i_fetch,
    input  wire logic [sjx_pkg::SJX_DW-1:0] i_file_data,
    input  wire logic [sjx_pkg::SJX_DW-1:0] i_pc_high_latch,
    output logic [sjx_pkg::SJX_AW-1:0]      o_file_addr,
    output sjx_pkg::sjx_write_type          o_write,
    output sjx_pkg::sjx_jump_type           o_jump,
    output logic                            o_flush,
    output logic                            o_flags_hold
);
    import sjx_pkg::*;

    // ==========================================================
    // Decode helpers
    // The skip patterns are tested in more than one place; each pattern lives in one function
    function automatic logic is_dec_skip(input logic [SJX_IW-1:0] w);
        return w[SJX_IW-1:SJX_SKIP_OP_LO] == SJX_OP_DEC_SKIP;
    endfunction : is_dec_skip

    function automatic logic is_inc_skip(input logic [SJX_IW-1:0] w);
        return w[SJX_IW-1:SJX_SKIP_OP_LO] == SJX_OP_INC_SKIP;
    endfunction : is_inc_skip

    function automatic logic is_skip(input logic [SJX_IW-1:0] w);
        return is_dec_skip(w) || is_inc_skip(w);
    endfunction : is_skip

    function automatic logic is_jump(input logic [SJX_IW-1:0] w);
        return w[SJX_IW-1:SJX_JUMP_OP_LO] == SJX_OP_JUMP;
    endfunction : is_jump

    function automatic logic [SJX_AW-1:0] file_field(input logic [SJX_IW-1:0] w);
        return w[SJX_AW-1:0];
    endfunction : file_field

    function automatic logic dest_field(input logic [SJX_IW-1:0] w);
        return w[SJX_DEST_BIT];
    endfunction : dest_field

    function automatic logic [SJX_LITW-1:0] literal_field(input logic [SJX_IW-1:0] w);
        return w[SJX_LITW-1:0];
    endfunction : literal_field

    function automatic logic [SJX_PCW-1:0] jump_target_of(input logic [SJX_DW-1:0] latch,
                                                          input logic [SJX_IW-1:0] w);
        return {latch[SJX_LATCH_HI:SJX_LATCH_LO], literal_field(w)};
    endfunction : jump_target_of

    // ==========================================================
    // Internal signals
    sjx_state_type          state;
    sjx_state_type          next_state;
    logic [SJX_IW-1:0]      word;
    logic                   live;
    logic                   dec_hit;
    logic                   inc_hit;
    logic                   skip_hit;
    logic                   jump_hit;
    logic                   dest_file;
    logic [SJX_DW-1:0]      next_result;
    logic                   zero;
    logic                   skip_taken;
    logic                   slot_burned;
    logic                   write_file;
    logic                   write_w;
    logic [SJX_AW-1:0]      write_addr;
    logic [SJX_DW-1:0]      write_data;
    logic                   jump_load;
    logic [SJX_PCW-1:0]     jump_target;

    // ==========================================================
    // Slot qualification
    // A word arriving in the flush slot is the discarded prefetch
    assign live = i_fetch.valid && (state == SJX_EXECUTE);

    // Forcing the no-op pattern keeps every decoder below quiet in that slot
    always_comb begin
        if (live) begin
            word = i_fetch.word;
        end else begin
            word = SJX_NOP_WORD;
        end
    end

    assign dec_hit   = is_dec_skip(word);
    assign inc_hit   = is_inc_skip(word);
    assign skip_hit  = is_skip(word);
    assign jump_hit  = is_jump(word);
    assign dest_file = dest_field(word);

    // ==========================================================
    // Register file read
    // Combinational so the file answers within the same slot
    assign o_file_addr = file_field(word);

    // ==========================================================
    // Arithmetic
    // Eight-bit result wraps mod 256 by width alone
    always_comb begin
        if (dec_hit) begin
            next_result = i_file_data - 8'h01;
        end else begin
            next_result = i_file_data + 8'h01;
        end
    end

    assign zero        = (next_result == 8'h00);
    assign skip_taken  = skip_hit && zero;
    assign slot_burned = skip_taken || jump_hit;

    // ==========================================================
    // Two-cycle sequencing
    // Skip-on-zero and jump both burn the following slot
    always_comb begin
        next_state = SJX_EXECUTE;
        unique case (state)
            SJX_EXECUTE: begin
                if (slot_burned) begin
                    next_state = SJX_FLUSH;
                end
            end
            SJX_FLUSH: begin
                next_state = SJX_EXECUTE;
            end
            default: begin
                next_state = SJX_EXECUTE;
            end
        endcase
    end

    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state <= SJX_EXECUTE;
        end else begin
            state <= next_state;
        end
    end

    // Flush marks the slot whose prefetched word runs as a no-op
    assign o_flush = (state == SJX_FLUSH);

    // ==========================================================
    // Write-back strobe to the file
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_file <= 1'b0;
        end else begin
            write_file <= skip_hit && dest_file;
        end
    end

    // ==========================================================
    // Write-back strobe to the working register
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_w <= 1'b0;
        end else begin
            write_w <= skip_hit && !dest_file;
        end
    end

    // ==========================================================
    // Write-back address
    // Payload follows every word; only the strobes make it count
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_addr <= '0;
        end else begin
            write_addr <= file_field(word);
        end
    end

    // ==========================================================
    // Write-back data
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            write_data <= '0;
        end else begin
            write_data <= next_result;
        end
    end

    assign o_write = {write_file, write_w, write_addr, write_data};

    // ==========================================================
    // Jump request
    // Load is a one-cycle pulse; the fetch unit refetches from the target
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            jump_load <= 1'b0;
        end else begin
            jump_load <= jump_hit;
        end
    end

    // ==========================================================
    // Jump target
    // Latch bits are taken with the jump word, not at the reload
    always_ff @(posedge i_clock or negedge i_rst_n) begin
        if (!i_rst_n) begin
            jump_target <= '0;
        end else begin
            jump_target <= jump_target_of(i_pc_high_latch, word);
        end
    end

    assign o_jump = {jump_load, jump_target};

    // ==========================================================
    // Status flags
    // None of the three touches a status flag; core keeps them while this is high
    assign o_flags_hold = dec_hit || inc_hit || jump_hit;

endmodule : sjx_exec
`default_nettype wire

// ---- sjx_exec_props.sv ----
/* Checker for sjx_exec, bound below.
   Assumes one clock and the async active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module sjx_exec_props (
    input wire logic                i_clock,
    input wire logic                i_rst_n,
    input wire sjx_pkg::sjx_fetch_type i_fetch,
    input wire logic [7:0]          i_file_data,
    input wire logic [7:0]          i_pc_high_latch,
    input wire logic [6:0]          o_file_addr,
    input wire sjx_pkg::sjx_write_type o_write,
    input wire sjx_pkg::sjx_jump_type  o_jump,
    input wire logic                o_flush,
    input wire logic                o_flags_hold
);
    import sjx_pkg::*;
    // ==========================================================
    // Properties
    default clocking @(posedge i_clock); endclocking
    default disable iff (!i_rst_n);
    wire logic t = i_fetch.valid && !o_flush;
    wire logic dec = t && i_fetch.word[13:8] == SJX_OP_DEC_SKIP;
    wire logic inc = t && i_fetch.word[13:8] == SJX_OP_INC_SKIP;
    wire logic jmp = t && i_fetch.word[13:11] == SJX_OP_JUMP;
    sequence slot_drop;
        o_flush ##1 !o_flush;
    endsequence
    chk_dec_step: assert property (dec |=> o_write.data == $past(i_file_data) - 8'h01
        && o_flush == ($past(i_file_data) == 8'h01)) else $error("decrement skip wrong");
    chk_inc_step: assert property (inc |=> o_write.data == $past(i_file_data) + 8'h01
        && o_flush == ($past(i_file_data) == 8'hff)) else $error("increment skip wrong");
    chk_skip_dest: assert property ((dec || inc) |=> o_write.we_file == $past(i_fetch.word[7])
        && o_write.we_w != $past(i_fetch.word[7])) else $error("destination wrong");
    chk_jump_target: assert property (jmp |=> o_jump.load
        && o_jump.target == {$past(i_pc_high_latch[4:3]), $past(i_fetch.word[10:0])}) else $error("jump target");
    chk_jump_slot: assert property (jmp |=> slot_drop) else $error("jump not two cycles");
    chk_flags_held: assert property ((dec || inc || jmp) |-> o_flags_hold) else $error("flags not held");
    chk_addr_field: assert property (t |-> o_file_addr == i_fetch.word[6:0]) else $error("file address");
    chk_flush_mute: assert property (o_flush |=> !o_write.we_file && !o_write.we_w
        && !o_jump.load) else $error("discarded word acted");
endmodule : sjx_exec_props
bind sjx_exec sjx_exec_props chk (.*);
`default_nettype wire

// ---- sjx_file_model.sv ----
/* Register file model facing sjx_exec.
   Assumes reads by address, write-back from o_write. */
`timescale 1ns/1ps
`default_nettype none
module sjx_file_model (
    input  wire logic                   i_clock,
    input  wire logic [6:0]             i_addr,
    input  wire sjx_pkg::sjx_write_type i_write,
    output logic [7:0]                  o_data
);
    import sjx_pkg::*;
    logic [7:0] mem [128];
    // Bypass pending write: back-to-back skips on one address see fresh data
    assign o_data = (i_write.we_file && i_write.addr == i_addr) ? i_write.data : mem[i_addr];
    initial for (int i = 0; i < 128; i++) mem[i] = {i[6:0], 1'b1};
    always @(posedge i_clock) if (i_write.we_file) mem[i_write.addr] <= i_write.data;
endmodule : sjx_file_model
`default_nettype wire

// ---- sjx_exec_bench.sv ----
/* Self-checking bench for sjx_exec.
   Assumes sjx_file_model holds {addr,1} at start. */
`timescale 1ns/1ps
`default_nettype none
module sjx_exec_bench;
    import sjx_pkg::*;
    logic i_clock = 1'b0, i_rst_n = 1'b0, fl, fh, skip = 1'b0, hold = 1'b0;
    sjx_fetch_type i_fetch = '0;
    logic [7:0] fdat, latch = 8'h00, shadow [128];
    logic [6:0] faddr;
    sjx_write_type wr;
    sjx_jump_type jp;
    logic [16:0] q_w[$], q_j[$], q_f[$];
    logic [13:0] dir [5] = '{14'h0b80, 14'h0fff, 14'h0f7f, 14'h2855, 14'h2aaa};
    int error_cnt = 0, num_checks = 0;
    initial forever #20 i_clock = ~i_clock;
    sjx_exec DUT (.i_clock(i_clock), .i_rst_n(i_rst_n), .i_fetch(i_fetch), .i_file_data(fdat),
        .i_pc_high_latch(latch), .o_file_addr(faddr), .o_write(wr), .o_jump(jp), .o_flush(fl), .o_flags_hold(fh));
    sjx_file_model fm (.i_clock(i_clock), .i_addr(faddr), .i_write(wr), .o_data(fdat));
    task automatic cmp(string n, logic [16:0] e, logic [16:0] g);
        num_checks++;
        if (e !== g) begin
            error_cnt++;
            $display("FAIL %s exp %h got %h", n, e, g);
        end
    endtask : cmp
    always @(negedge i_clock) if (i_rst_n) begin
        if (wr.we_file || wr.we_w) cmp("write", q_w.size() ? q_w.pop_front() : 'x, wr);
        if (jp.load) cmp("jump", q_j.size() ? q_j.pop_front() : 'x, 17'(jp));
        if (fl) cmp("flush", q_f.size() ? q_f.pop_front() : 'x, 17'(fl));
        cmp("hold", 17'(hold), 17'(fh));
    end
    task automatic issue(logic [13:0] w);
        logic [7:0] v, l;
        @(posedge i_clock);
        l = 8'($urandom);
        i_fetch <= {1'b1, w};
        latch <= l;
        v = shadow[w[6:0]];
        hold = 1'b0;
        if (skip) skip = 1'b0;
        else if (w[13:11] == SJX_OP_JUMP) begin
            q_j.push_back({3'h0, 1'b1, l[4:3], w[10:0]});
            q_f.push_back(17'h1);
            hold = 1'b1;
            skip = 1'b1;
        end else if (w[13:8] == SJX_OP_DEC_SKIP || w[13:8] == SJX_OP_INC_SKIP) begin
            v = w[10] ? v + 8'h01 : v - 8'h01;
            q_w.push_back({w[7], !w[7], w[6:0], v});
            if (w[7]) shadow[w[6:0]] = v;
            skip = (v == 8'h00);
            hold = 1'b1;
            if (skip) q_f.push_back(17'h1);
        end
    endtask : issue
    function automatic logic [13:0] rnd();
        logic [6:0] a = ($urandom % 2) ? 7'h7f : 7'($urandom % 4);
        logic d = 1'($urandom);
        case ($urandom % 4)
            0: return {SJX_OP_DEC_SKIP, d, a};
            1: return {SJX_OP_INC_SKIP, d, a};
            2: return {SJX_OP_JUMP, 11'($urandom)};
            default: return {6'h0a, d, a};
        endcase
    endfunction : rnd
    task automatic end_of_test();
        $display("checks %0d errors %0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : end_of_test
    initial begin
        void'($urandom(74562));
        for (int i = 0; i < 128; i++) shadow[i] = {i[6:0], 1'b1};
        repeat (8) @(posedge i_clock);
        i_rst_n <= 1'b1;
        foreach (dir[i]) issue(dir[i]);
        $display("test directed done");
        repeat (200) issue(rnd());
        @(posedge i_clock);
        i_fetch <= '0;
        hold = 1'b0;
        repeat (3) @(posedge i_clock);
        cmp("left", 17'h0, 17'(q_w.size() + q_j.size() + q_f.size()));
        $display("test random done");
        end_of_test();
    end
    initial begin
        #40000;
        error_cnt++;
        end_of_test();
    end
endmodule : sjx_exec_bench
`default_nettype wire
